// *** logic/spt_top.sv ***
// spt_top: self polling timer and control sequencer
// assumes: receiver front end gives sync, wake-up and fail as levels
// Operation
// - constant mode: on time bounds each channel
// - separate on times for config A and B
// - constant period: off plus every channel on
// - fast fall back shuts receiver early
// - sync search runs beside wake-up search
// - no sync before timeout abandons channel
// - held sync keeps evaluating until decided or the on window ends
// - failed channel hops next or sleeps
// - fast mode uses only config A on time
// - one A on time covers all channels
// - early shutdown leaves on timer running
// - fast period constant: on plus off
// - one window bounds all channels together
// - mixed: A constant, B fast fall back
// - mixed: B on time bounds all B
// - mixed period: off, A per channel, B once
// - fast period equals off plus on
// - two-bit mode select 00 01 10
// - reference divide 64 then value, 0 is 256
// - off time count, zero means 16384
// - wake-up enters run mode
`timescale 1ns/1ns
`default_nettype none
module spt_top
  import spt_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       sync_found_in,
  input  wire logic       sync_timeout_in,
  input  wire logic       wakeup_in,
  input  wire logic       wakeup_fail_in,
  input  wire logic       run_exit_in,
  output logic            rx_on_out,
  output logic            cfg_b_out,
  output logic      [3:0] channel_out,
  output logic            hop_out,
  output logic            run_mode_out
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0] ctrl_q, ctrl_d, refdiv_q, refdiv_d;
  logic [7:0] off_lo_q, off_lo_d, off_hi_q, off_hi_d;
  logic [7:0] aon_lo_q, aon_lo_d, aon_hi_q, aon_hi_d;
  logic [7:0] bon_lo_q, bon_lo_d, bon_hi_q, bon_hi_d;
  logic [7:0] chan_q, chan_d, rdata_q, rdata_d;
  spt_state_e state_q, state_d;
  logic [3:0] ch_q, ch_d;
  logic       rx_q, rx_d, hop_q, hop_d;

  always_comb begin
    ctrl_d   = ctrl_q;
    refdiv_d = refdiv_q;
    off_lo_d = off_lo_q;
    off_hi_d = off_hi_q;
    aon_lo_d = aon_lo_q;
    aon_hi_d = aon_hi_q;
    bon_lo_d = bon_lo_q;
    bon_hi_d = bon_hi_q;
    chan_d   = chan_q;
    if (wr_in) begin
      unique case (addr_in)
        SPT_ADDR_CTRL:   ctrl_d   = wdata_in & 8'h0f;
        SPT_ADDR_REFDIV: refdiv_d = wdata_in;
        SPT_ADDR_OFF_LO: off_lo_d = wdata_in;
        SPT_ADDR_OFF_HI: off_hi_d = wdata_in & 8'h3f;
        SPT_ADDR_AON_LO: aon_lo_d = wdata_in;
        SPT_ADDR_AON_HI: aon_hi_d = wdata_in & 8'h3f;
        SPT_ADDR_BON_LO: bon_lo_d = wdata_in;
        SPT_ADDR_BON_HI: bon_hi_d = wdata_in & 8'h3f;
        SPT_ADDR_CHAN:   chan_d   = wdata_in;
        default:         ;
      endcase
    end
    rdata_d = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        SPT_ADDR_CTRL:   rdata_d = ctrl_q;
        SPT_ADDR_REFDIV: rdata_d = refdiv_q;
        SPT_ADDR_OFF_LO: rdata_d = off_lo_q;
        SPT_ADDR_OFF_HI: rdata_d = off_hi_q;
        SPT_ADDR_AON_LO: rdata_d = aon_lo_q;
        SPT_ADDR_AON_HI: rdata_d = aon_hi_q;
        SPT_ADDR_BON_LO: rdata_d = bon_lo_q;
        SPT_ADDR_BON_HI: rdata_d = bon_hi_q;
        SPT_ADDR_CHAN:   rdata_d = chan_q;
        SPT_ADDR_STATUS: rdata_d = {1'b0, 3'(state_q), ch_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q   <= SPT_RST_CTRL;
      refdiv_q <= SPT_RST_REFDIV;
      off_lo_q <= SPT_RST_OFF_LO;
      off_hi_q <= SPT_RST_OFF_HI;
      aon_lo_q <= SPT_RST_ON_LO;
      aon_hi_q <= SPT_RST_ON_HI;
      bon_lo_q <= SPT_RST_ON_LO;
      bon_hi_q <= SPT_RST_ON_HI;
      chan_q   <= SPT_RST_CHAN;
      rdata_q  <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      refdiv_q <= refdiv_d;
      off_lo_q <= off_lo_d;
      off_hi_q <= off_hi_d;
      aon_lo_q <= aon_lo_d;
      aon_hi_q <= aon_hi_d;
      bon_lo_q <= bon_lo_d;
      bon_hi_q <= bon_hi_d;
      chan_q   <= chan_d;
      rdata_q  <= rdata_d;
    end
  end

  // ***************************************************************
  // timer stage
  // ***************************************************************
  spt_tick_if tick_if ();

  spt_ref_timer u_ref (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_q),
    .divider_in (refdiv_q),
    .tick_if    (tick_if.refgen)
  );

  spt_period_timer u_per (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_q),
    .tick_if  (tick_if.timer)
  );

  // ***************************************************************
  // sequencer
  // ***************************************************************
  logic [1:0]            mode;
  logic                  run_en, dual;
  logic [3:0]            a_cnt, b_cnt;
  logic [SPT_TIME_W-1:0] off_t, aon_t, bon_t;
  logic                  a_fast, b_fast, ch_fast, ch_end, last_ch;
  logic                  load_d, load_q;
  logic [SPT_TIME_W-1:0] cnt_d, cnt_q;

  assign mode    = ctrl_q[1:0];
  assign run_en  = ctrl_q[SPT_CTRL_RUN_BIT];
  assign dual    = ctrl_q[SPT_CTRL_DUAL_BIT];
  assign a_cnt   = (chan_q[3:0] == 4'h0) ? 4'h1 : chan_q[3:0];
  assign b_cnt   = (chan_q[7:4] == 4'h0) ? 4'h1 : chan_q[7:4];
  assign off_t   = {off_hi_q[5:0], off_lo_q};
  assign aon_t   = {aon_hi_q[5:0], aon_lo_q};
  assign bon_t   = {bon_hi_q[5:0], bon_lo_q};
  // mixed mode: A constant, B fast
  assign a_fast  = (mode == SPT_MODE_FFB);
  assign b_fast  = (mode == SPT_MODE_FFB) || (mode == SPT_MODE_MIXED);
  assign ch_fast = (state_q == SPT_ON_A) ? a_fast : b_fast;
  // held sync waits for a decision
  assign ch_end  = ch_fast &&
                   ((sync_timeout_in && !sync_found_in) || wakeup_fail_in);
  // single config never counts B channels
  assign last_ch = (state_q == SPT_ON_A) ?
                   (ch_q + 4'h1 == a_cnt) && !dual :
                   (ch_q + 4'h1 == b_cnt);

  always_comb begin
    state_d = state_q;
    ch_d    = ch_q;
    rx_d    = rx_q;
    hop_d   = 1'b0;
    load_d  = 1'b0;
    cnt_d   = cnt_q;
    unique case (state_q)
      SPT_IDLE: begin
        if (run_en) begin
          state_d = SPT_ON_A;
          ch_d    = 4'h0;
          rx_d    = 1'b1;
          load_d  = 1'b1;
          cnt_d   = aon_t;
        end
      end
      SPT_ON_A, SPT_ON_B: begin
        if (wakeup_in) begin
          // wake-up leaves polling for run mode
          state_d = SPT_RUN;
        end else if (ch_end && !last_ch) begin
          hop_d = 1'b1;
          if (state_q == SPT_ON_A && ch_q + 4'h1 == a_cnt) begin
            state_d = SPT_ON_B;
            ch_d    = 4'h0;
          end else begin
            ch_d = ch_q + 4'h1;
          end
        end else if (ch_end) begin
          // timer keeps running to full on time
          state_d = SPT_HOLD;
          rx_d    = 1'b0;
        end else if (tick_if.expired) begin
          hop_d = 1'b1;
          if (state_q == SPT_ON_A && !a_fast && !last_ch &&
              ch_q + 4'h1 != a_cnt) begin
            ch_d   = ch_q + 4'h1;
            load_d = 1'b1;
          end else if (state_q == SPT_ON_A && !a_fast && dual) begin
            state_d = SPT_ON_B;
            ch_d    = 4'h0;
            load_d  = !b_fast || 1'b1;
            cnt_d   = bon_t;
          end else if (state_q == SPT_ON_B && !b_fast && !last_ch) begin
            ch_d   = ch_q + 4'h1;
            load_d = 1'b1;
          end else begin
            // last window done, count the off time
            state_d = SPT_OFF;
            rx_d    = 1'b0;
            hop_d   = 1'b0;
            load_d  = 1'b1;
            cnt_d   = off_t;
          end
        end
      end
      SPT_HOLD: begin
        if (tick_if.expired) begin
          state_d = SPT_OFF;
          load_d  = 1'b1;
          cnt_d   = off_t;
        end
      end
      SPT_OFF: begin
        if (!run_en) begin
          state_d = SPT_IDLE;
        end else if (tick_if.expired) begin
          // fast mode window from A on time
          state_d = SPT_ON_A;
          ch_d    = 4'h0;
          rx_d    = 1'b1;
          load_d  = 1'b1;
          cnt_d   = aon_t;
        end
      end
      SPT_RUN: begin
        if (run_exit_in) begin
          state_d = SPT_IDLE;
          rx_d    = 1'b0;
        end
      end
      default: state_d = SPT_IDLE;
    endcase
    if (!run_en && state_q != SPT_RUN) begin
      state_d = SPT_IDLE;
      rx_d    = 1'b0;
    end
  end

  // mixed mode B window loaded once for all B channels
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= SPT_IDLE;
      ch_q    <= 4'h0;
      rx_q    <= 1'b0;
      hop_q   <= 1'b0;
      load_q  <= 1'b0;
      cnt_q   <= SPT_TIME_ZERO;
    end else begin
      state_q <= state_d;
      ch_q    <= ch_d;
      rx_q    <= rx_d;
      hop_q   <= hop_d;
      load_q  <= load_d;
      cnt_q   <= cnt_d;
    end
  end

  assign tick_if.load  = load_q;
  assign tick_if.count = cnt_q;

  logic cfg_b_q, run_q;
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_b_q <= 1'b0;
      run_q   <= 1'b0;
    end else begin
      cfg_b_q <= (state_d == SPT_ON_B);
      run_q   <= (state_d == SPT_RUN);
    end
  end

  assign rdata_out    = rdata_q;
  assign rx_on_out    = rx_q;
  assign cfg_b_out    = cfg_b_q;
  assign channel_out  = ch_q;
  assign hop_out      = hop_q;
  assign run_mode_out = run_q;
endmodule
`default_nettype wire

// *** include/spt_pkg.sv ***
// spt_pkg: constants and types shared by the self polling timer files
// assumes: nothing beyond a SystemVerilog compiler
package spt_pkg;

  // ***************************************************************
  // register map, byte offsets
  // ***************************************************************
  localparam logic [3:0] SPT_ADDR_CTRL    = 4'h0;
  localparam logic [3:0] SPT_ADDR_REFDIV  = 4'h1;
  localparam logic [3:0] SPT_ADDR_OFF_LO  = 4'h2;
  localparam logic [3:0] SPT_ADDR_OFF_HI  = 4'h3;
  localparam logic [3:0] SPT_ADDR_AON_LO  = 4'h4;
  localparam logic [3:0] SPT_ADDR_AON_HI  = 4'h5;
  localparam logic [3:0] SPT_ADDR_BON_LO  = 4'h6;
  localparam logic [3:0] SPT_ADDR_BON_HI  = 4'h7;
  localparam logic [3:0] SPT_ADDR_CHAN    = 4'h8;
  localparam logic [3:0] SPT_ADDR_STATUS  = 4'h9;

  // ***************************************************************
  // field positions and reset values
  // ***************************************************************
  localparam int         SPT_CTRL_RUN_BIT   = 2;
  localparam int         SPT_CTRL_DUAL_BIT  = 3;
  localparam int         SPT_CHAN_B_POS     = 4;
  localparam logic [7:0] SPT_RST_CTRL       = 8'h00;
  localparam logic [7:0] SPT_RST_REFDIV     = 8'h01;
  localparam logic [7:0] SPT_RST_OFF_LO     = 8'h01;
  localparam logic [7:0] SPT_RST_OFF_HI     = 8'h00;
  localparam logic [7:0] SPT_RST_ON_LO      = 8'h01;
  localparam logic [7:0] SPT_RST_ON_HI      = 8'h00;
  localparam logic [7:0] SPT_RST_CHAN       = 8'h11;

  // ***************************************************************
  // timing: system clock prescale before the reference divider
  // ***************************************************************
  localparam int         SPT_PRESCALE       = 64;
  localparam int         SPT_PRESCALE_W     = 6;
  localparam int         SPT_TIME_W         = 14;
  localparam logic [13:0] SPT_TIME_ZERO     = 14'h0000;

  // ***************************************************************
  // polling modes and sequencer states
  // ***************************************************************
  localparam logic [1:0] SPT_MODE_CONST     = 2'h0;
  localparam logic [1:0] SPT_MODE_FFB       = 2'h1;
  localparam logic [1:0] SPT_MODE_MIXED     = 2'h2;

  typedef enum logic [2:0] {
    SPT_IDLE,
    SPT_ON_A,
    SPT_ON_B,
    SPT_HOLD,
    SPT_OFF,
    SPT_RUN
  } spt_state_e;

endpackage

// *** include/spt_tick_if.sv ***
// spt_tick_if: reference tick and period timer handshake
// assumes: one clock domain, driven by spt_top
`timescale 1ns/1ns
`default_nettype none
interface spt_tick_if;
  import spt_pkg::*;
  logic                  tick;
  logic                  load;
  logic [SPT_TIME_W-1:0] count;
  logic                  expired;
  modport refgen (output tick);
  modport timer  (input tick, input load, input count, output expired);
  modport ctrl   (input tick, output load, output count, input expired);
endinterface
`default_nettype wire

// *** logic/spt_ref_timer.sv ***
// spt_ref_timer: fsys/64 prescaler and 8-bit reference divider
// assumes: synchronous reset copy from the top
`timescale 1ns/1ns
`default_nettype none
module spt_ref_timer
  import spt_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] divider_in,
  spt_tick_if.refgen      tick_if
);
  logic [SPT_PRESCALE_W-1:0] pre_q, pre_d;
  logic [7:0]                div_q, div_d;
  logic                      tick_q, tick_d;

  // ***************************************************************
  // divider
  // ***************************************************************
  // divide by 64 then by value, zero is 256
  always_comb begin
    pre_d  = pre_q + 6'h01;
    div_d  = div_q;
    tick_d = 1'b0;
    if (pre_q == 6'(SPT_PRESCALE - 1)) begin
      if (div_q + 8'h01 == divider_in) begin
        div_d  = 8'h00;
        tick_d = 1'b1;
      end else begin
        div_d  = div_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q  <= '0;
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_if.tick = tick_q;
endmodule
`default_nettype wire

// *** logic/spt_period_timer.sv ***
// spt_period_timer: counts reference ticks down from a loaded value
// assumes: load and tick from the same clock domain
`timescale 1ns/1ns
`default_nettype none
module spt_period_timer
  import spt_pkg::*;
(
  input  wire logic  clk_in,
  input  wire logic  rst_n_in,
  spt_tick_if.timer  tick_if
);
  logic [SPT_TIME_W:0] cnt_q, cnt_d;
  logic                exp_q, exp_d;

  // ***************************************************************
  // countdown
  // ***************************************************************
  // zero count means full 16384 periods
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (tick_if.load) begin
      cnt_d = (tick_if.count == SPT_TIME_ZERO) ?
              {1'b1, SPT_TIME_ZERO} : {1'b0, tick_if.count};
    end else if (tick_if.tick && cnt_q != '0) begin
      cnt_d = cnt_q - 15'h0001;
      exp_d = (cnt_q == 15'h0001);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign tick_if.expired = exp_q;
endmodule
`default_nettype wire

// *** testbench/spt_front_end.sv ***
// spt_front_end: receiver front end with sync and wake-up flags
// assumes: bench clock, behaviour picked by mode_in
`timescale 1ns/1ns
`default_nettype none
module spt_front_end (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       rx_on_in,
  input  wire logic       cfg_b_in,
  input  wire logic [3:0] channel_in,
  input  wire logic       hop_in,
  output logic            sync_found_out,
  output logic            sync_timeout_out,
  output logic            wakeup_out,
  output logic            wakeup_fail_out
);
  // mode 0 silent, 1 wakes, 2 fails after sync, 3 sync held undecided
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [4:0] pos_q;
  logic       done;
  always_comb begin
    cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
    if (!rx_on_in || hop_in || {cfg_b_in, channel_in} != pos_q) begin
      cnt_d = 8'h00;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 8'h00;
      pos_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
      pos_q <= {cfg_b_in, channel_in};
    end
  end
  assign done = rx_on_in && cnt_q == 8'h14;
  assign sync_found_out   = rx_on_in && mode_in != 2'h0 && cnt_q >= 8'h0a;
  assign sync_timeout_out = done && (mode_in == 2'h0 || mode_in == 2'h3);
  assign wakeup_out       = done && mode_in == 2'h1;
  assign wakeup_fail_out  = done && mode_in == 2'h2;
endmodule
`default_nettype wire

// *** testbench/spt_top_props.sv ***
// spt_top_props: port level checks on the polling timer
// assumes: bound to spt_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module spt_top_props
  import spt_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       sync_found_in,
  input wire logic       sync_timeout_in,
  input wire logic       wakeup_in,
  input wire logic       wakeup_fail_in,
  input wire logic       run_exit_in,
  input wire logic       rx_on_out,
  input wire logic       cfg_b_out,
  input wire logic       hop_out,
  input wire logic       run_mode_out
);
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic       ffb;
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_in && addr_in == SPT_ADDR_CTRL) ctrl_d = wdata_in;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) ctrl_q <= SPT_RST_CTRL;
    else ctrl_q <= ctrl_d;
  end
  assign ffb = ctrl_q[1:0] == SPT_MODE_FFB;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (rd_in && addr_in > SPT_ADDR_STATUS
    |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  a_hi_bits_zero: assert property (
    rd_in && addr_in inside {4'h3, 4'h5, 4'h7} |=> rdata_out[7:6] == 2'b00)
    else $error("time high byte top bits set");
  a_hop_single: assert property (hop_out |=> !hop_out)
    else $error("hop pulse too long");
  a_run_holds: assert property (
    run_mode_out && !run_exit_in |=> run_mode_out)
    else $error("run mode left without exit");
  a_wake_run: assert property (
    wakeup_in && rx_on_out |-> ##[1:4] run_mode_out)
    else $error("wake-up did not enter run mode");
  a_timeout_drop: assert property (
    ffb && $past(ffb) && rx_on_out && sync_timeout_in && !sync_found_in
    |-> ##[1:3] (hop_out || !rx_on_out)) else $error("timeout kept channel");
  a_fail_drop: assert property (
    ffb && $past(ffb) && rx_on_out && wakeup_fail_in
    |-> ##[1:3] (hop_out || !rx_on_out)) else $error("failed channel kept");
  a_single_no_b: assert property (
    !ctrl_q[3] && !$past(ctrl_q[3]) && !$past(ctrl_q[3], 3) && rx_on_out
    |-> !cfg_b_out) else $error("config b scanned in single mode");
  a_idle_rx_off: assert property (!ctrl_q[2] && !$past(ctrl_q[2])
    && !$past(ctrl_q[2], 3) && !run_mode_out && !$past(run_mode_out)
    && !$past(run_mode_out, 2) |-> !rx_on_out)
    else $error("receiver on while disabled");
endmodule
bind spt_top spt_top_props i_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .sync_found_in(sync_found_in),
  .sync_timeout_in(sync_timeout_in), .wakeup_in(wakeup_in),
  .wakeup_fail_in(wakeup_fail_in), .run_exit_in(run_exit_in),
  .rx_on_out(rx_on_out), .cfg_b_out(cfg_b_out), .hop_out(hop_out),
  .run_mode_out(run_mode_out)
);
`default_nettype wire

// *** testbench/self_polling_timer_bench.sv ***
// self_polling_timer_bench: register and period tests of spt_top
// assumes: front end model beside the design, 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module self_polling_timer_bench;
  import spt_pkg::*;
  logic       clk_in, rst_n_in, wr_in, rd_in, run_exit_in;
  logic [3:0] addr_in, channel_out;
  logic [7:0] wdata_in, rdata_out;
  logic [1:0] fe_mode;
  logic       rx_on_out, cfg_b_out, hop_out, run_mode_out;
  logic       sync_found, sync_timeout, wakeup, wakeup_fail;
  int         err_count, checked, per, ona, onb, n;
  int         cyc = 0;
  logic [7:0] rv [0:9] = '{SPT_RST_CTRL, SPT_RST_REFDIV, SPT_RST_OFF_LO,
    SPT_RST_OFF_HI, SPT_RST_ON_LO, SPT_RST_ON_HI, SPT_RST_ON_LO,
    SPT_RST_ON_HI, SPT_RST_CHAN, 8'h00};
  spt_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .sync_found_in(sync_found),
    .sync_timeout_in(sync_timeout), .wakeup_in(wakeup),
    .wakeup_fail_in(wakeup_fail), .run_exit_in(run_exit_in),
    .rx_on_out(rx_on_out), .cfg_b_out(cfg_b_out),
    .channel_out(channel_out), .hop_out(hop_out),
    .run_mode_out(run_mode_out));
  spt_front_end i_fe (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .mode_in(fe_mode), .rx_on_in(rx_on_out), .cfg_b_in(cfg_b_out),
    .channel_in(channel_out), .hop_in(hop_out),
    .sync_found_out(sync_found), .sync_timeout_out(sync_timeout),
    .wakeup_out(wakeup), .wakeup_fail_out(wakeup_fail));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // cycle counts within 20 cycles, under a third of a 64-cycle reference tick, pass
  task automatic near(input string nm, input int seen, exp);
    chk(nm, (seen >= exp - 20 && seen <= exp + 20) ? exp : seen, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [3:0] a, logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(nm, rdata_out, e);
  endtask
  // skips to the second whole master period after start
  task automatic meas();
    logic p;
    for (int k = 0; k < 3; k++) begin
      per = 0;
      ona = 0;
      onb = 0;
      do begin
        p = rx_on_out;
        @(negedge clk_in);
        per++;
        if (rx_on_out === 1'b1 && cfg_b_out === 1'b1) onb++;
        else if (rx_on_out === 1'b1) ona++;
      end while (!(p === 1'b0 && rx_on_out === 1'b1) && per < 40000);
    end
  endtask
  task automatic run(input logic [7:0] c, input logic [1:0] m);
    wr(SPT_ADDR_CTRL, 8'h00);
    fe_mode <= m;
    wr(SPT_ADDR_CTRL, c);
    meas();
  endtask
  initial begin
    {wr_in, rd_in, run_exit_in} = 3'h0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    fe_mode = 2'h0;
    err_count = 0;
    checked = 0;
    rst_n_in = 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 10; i++) rd("reset", i[3:0], rv[i]);
    rd("unmapped", 4'ha, 8'h00);
    wr(SPT_ADDR_OFF_HI, 8'hff);
    rd("off hi", SPT_ADDR_OFF_HI, 8'h3f);
    // tick 64 cycles: on a 3, on b 5, off 7, one a and two b channels
    wr(SPT_ADDR_OFF_HI, 8'h00);
    wr(SPT_ADDR_OFF_LO, 8'h07);
    wr(SPT_ADDR_AON_LO, 8'h03);
    wr(SPT_ADDR_BON_LO, 8'h05);
    wr(SPT_ADDR_CHAN, 8'h21);
    run(8'h0c, 2'h0);
    near("const period", per, 1280);
    near("const a on", ona, 192);
    near("const b on", onb, 640);
    for (int m = 0; m < 3; m += 2) begin
      run(8'h0d, m[1:0]);
      near("fast period", per, 640);
      chk("fast early off", ona + onb < 150, 1);
    end
    run(8'h0d, 2'h3);
    near("held sync", ona + onb, 192);
    near("held period", per, 640);
    run(8'h05, 2'h3);
    near("fast single", per, 640);
    run(8'h0e, 2'h0);
    near("mixed period", per, 960);
    near("mixed a on", ona, 192);
    chk("mixed b early", onb < 150, 1);
    run(8'h04, 2'h0);
    near("single period", per, 640);
    chk("single no b", onb, 0);
    wr(SPT_ADDR_CTRL, 8'h00);
    fe_mode <= 2'h1;
    wr(SPT_ADDR_CTRL, 8'h0d);
    n = 0;
    while (run_mode_out !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    chk("wake", run_mode_out, 1'b1);
    wr(SPT_ADDR_CTRL, 8'h00);
    @(negedge clk_in);
    chk("run held", run_mode_out, 1'b1);
    @(posedge clk_in);
    run_exit_in <= 1'b1;
    @(posedge clk_in);
    run_exit_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    chk("run left", run_mode_out, 1'b0);
    wr(SPT_ADDR_REFDIV, 8'h00);
    wr(SPT_ADDR_OFF_LO, 8'h01);
    wr(SPT_ADDR_AON_LO, 8'h01);
    run(8'h04, 2'h0);
    near("div zero on", ona, 16384);
    near("div zero period", per, 32768);
    summarize();
  end
endmodule
`default_nettype wire
